//--- verilog/ofbs_pkg.sv
// constants for the offset and bit-sync loop configuration block
// assumes one 25 MHz digital clock and the chip reset for all users
package ofbs_pkg;

    // register addresses on the internal configuration port
    localparam logic [5:0] OFBS_ADDR_FREQ_CFG = 6'h19;
    localparam logic [5:0] OFBS_ADDR_BSYNC_CFG = 6'h1A;

    // reset values of the two registers
    localparam logic [7:0] OFBS_FREQ_CFG_RESET = 8'h36;
    localparam logic [7:0] OFBS_BSYNC_CFG_RESET = 8'h6C;

    // writable bits of the frequency register, 7:6 read as zero
    localparam logic [7:0] OFBS_FREQ_CFG_MASK = 8'h3F;

    // field positions in the frequency register
    localparam int OFBS_GATE_BIT = 5;
    localparam int OFBS_FPRE_HI = 4;
    localparam int OFBS_FPRE_LO = 3;
    localparam int OFBS_FPOST_BIT = 2;
    localparam int OFBS_FLIM_HI = 1;
    localparam int OFBS_FLIM_LO = 0;

    // field positions in the bit-sync register
    localparam int OFBS_KI_PRE_HI = 7;
    localparam int OFBS_KI_PRE_LO = 6;
    localparam int OFBS_KP_PRE_HI = 5;
    localparam int OFBS_KP_PRE_LO = 4;
    localparam int OFBS_KI_POST_BIT = 3;
    localparam int OFBS_KP_POST_BIT = 2;
    localparam int OFBS_RLIM_HI = 1;
    localparam int OFBS_RLIM_LO = 0;

    // loop indices for the gain selectors
    localparam int OFBS_LOOPS = 3;
    localparam int OFBS_LOOP_FREQ = 0;
    localparam int OFBS_LOOP_KI = 1;
    localparam int OFBS_LOOP_KP = 2;

    // gains are counted in halves of the base gain
    localparam logic [3:0] OFBS_GAIN_HALF = 4'h1;
    localparam logic [3:0] OFBS_GAIN_FULL = 4'h2;

    // post-sync gain per loop when its post bit is set
    localparam logic [3:0] OFBS_POST_GAIN [OFBS_LOOPS] = '{4'h1, 4'h1, 4'h2};

    // saturation codes
    localparam logic [1:0] OFBS_LIM_OFF = 2'h0;
    localparam logic [1:0] OFBS_LIM_1 = 2'h1;
    localparam logic [1:0] OFBS_LIM_2 = 2'h2;
    localparam logic [1:0] OFBS_LIM_3 = 2'h3;

    // frequency limit as a right shift of channel bandwidth
    localparam logic [2:0] OFBS_FSHIFT_NONE = 3'h0;
    localparam logic [2:0] OFBS_FSHIFT_DIV8 = 3'h3;
    localparam logic [2:0] OFBS_FSHIFT_DIV4 = 3'h2;
    localparam logic [2:0] OFBS_FSHIFT_DIV2 = 3'h1;

    // rate limit as a right shift of the data rate
    localparam logic [2:0] OFBS_RSHIFT_NONE = 3'h0;
    localparam logic [2:0] OFBS_RSHIFT_DIV32 = 3'h5;
    localparam logic [2:0] OFBS_RSHIFT_DIV16 = 3'h4;
    localparam logic [2:0] OFBS_RSHIFT_DIV8 = 3'h3;

    // reception phase
    typedef enum logic {
        OFBS_WAIT_SYNC,
        OFBS_SYNCED
    } ofbs_phase_t;

endpackage : ofbs_pkg

//--- verilog/ofbs_gain_sel.sv
// one loop gain selector with a registered gain output
// assumes pre code and post bit come from registers on the same clock
module ofbs_gain_sel
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // selection
    input wire logic [1:0] pre_code_in,
    input wire logic post_bit_in,
    input wire logic [3:0] post_gain_in,
    input wire logic after_sync_in,
    // gain in halves of the base gain
    output logic [3:0] gain_out
);

    logic [3:0] gain_q; // registered gain
    logic [3:0] pre_gain; // gain before sync

    // pre-sync gain is (code + 1) times base, in halves
    always_comb
    begin
        pre_gain = {1'b0, ({1'b0, pre_code_in} + 3'h1)} << 1;
    end

    // post bit set after sync picks the fixed post gain
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            gain_q <= ofbs_pkg::OFBS_GAIN_FULL;
        end
        else if (after_sync_in && post_bit_in)
        begin
            gain_q <= post_gain_in;
        end
        else
        begin
            gain_q <= pre_gain;
        end
    end

    assign gain_out = gain_q;

endmodule : ofbs_gain_sel

//--- verilog/ofbs_loop_config.sv
// configuration registers for frequency offset and clock recovery loops
// assumes a register port from the serial decoder and demodulator
// events on the same clock; no synchronisers are needed

// Overview of operation
// - post bit set gives half base frequency gain after sync
// - frequency limit codes zero, eighth, quarter, half
// - frequency limit zero disables offset compensation
// - integral gain before sync is code plus one
// - proportional gain before sync is code plus one
// - integral post bit set gives half base
// - proportional post bit set gives base gain
// - rate limit codes give 3.125, 6.25, 12.5 percent
// - rate limit zero disables rate compensation
// - frequency gain before sync is code plus one
// - gating bit freezes loops until carrier sense
module ofbs_loop_config
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [5:0] cfg_addr_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_wdata_in,
    input wire logic cfg_rd_in,
    output logic [7:0] cfg_rdata_out,
    output logic cfg_hit_out,
    // demodulator events
    input wire logic rx_start_in,
    input wire logic sync_found_in,
    input wire logic carrier_sense_in,
    // frequency loop controls
    output logic [3:0] freq_gain_out,
    output logic freq_comp_enable_out,
    output logic [2:0] freq_limit_shift_out,
    // clock recovery controls
    output logic [3:0] clkrec_integral_gain_out,
    output logic [3:0] clkrec_proportional_gain_out,
    output logic rate_comp_enable_out,
    output logic [2:0] rate_limit_shift_out,
    // loop freeze and phase
    output logic loop_freeze_out,
    output logic after_sync_out
);

    // register storage
    logic [7:0] freq_offset_comp_config_q; // frequency register
    logic [7:0] bit_sync_config_q; // bit-sync register
    logic [7:0] cfg_rdata_q; // read data

    // reception phase
    ofbs_pkg::ofbs_phase_t phase_q; // wait or synced
    logic after_sync; // phase decoded

    // carrier sense tracking
    logic carrier_seen_q; // carrier seen this reception
    logic loop_freeze_q; // registered freeze

    // limit outputs
    logic freq_comp_enable_q; // frequency compensation on
    logic [2:0] freq_limit_shift_q; // frequency limit shift
    logic rate_comp_enable_q; // rate compensation on
    logic [2:0] rate_limit_shift_q; // rate limit shift

    // decoded fields
    logic loop_freeze_until_carrier; // gating bit
    logic [1:0] freq_gain_before_sync; // frequency pre code
    logic freq_gain_after_sync; // frequency post bit
    logic [1:0] freq_offset_saturation; // frequency limit
    logic [1:0] clkrec_integral_before_sync; // integral pre code
    logic [1:0] clkrec_proportional_before_sync; // proportional pre code
    logic clkrec_integral_after_sync; // integral post bit
    logic clkrec_proportional_after_sync; // proportional post bit
    logic [1:0] rate_offset_saturation; // rate limit

    // per-loop selector wiring
    logic [1:0] pre_codes [ofbs_pkg::OFBS_LOOPS]; // pre codes
    logic post_bits [ofbs_pkg::OFBS_LOOPS]; // post bits
    logic [3:0] gains [ofbs_pkg::OFBS_LOOPS]; // selected gains

    // address decode
    logic hit_freq; // frequency register addressed
    logic hit_bsync; // bit-sync register addressed

    // field extraction from the frequency register
    always_comb
    begin
        loop_freeze_until_carrier = freq_offset_comp_config_q[ofbs_pkg::OFBS_GATE_BIT];
        freq_gain_before_sync = freq_offset_comp_config_q[ofbs_pkg::OFBS_FPRE_HI:ofbs_pkg::OFBS_FPRE_LO];
        freq_gain_after_sync = freq_offset_comp_config_q[ofbs_pkg::OFBS_FPOST_BIT];
        freq_offset_saturation = freq_offset_comp_config_q[ofbs_pkg::OFBS_FLIM_HI:ofbs_pkg::OFBS_FLIM_LO];
    end

    // field extraction from the bit-sync register
    always_comb
    begin
        clkrec_integral_before_sync = bit_sync_config_q[ofbs_pkg::OFBS_KI_PRE_HI:ofbs_pkg::OFBS_KI_PRE_LO];
        clkrec_proportional_before_sync = bit_sync_config_q[ofbs_pkg::OFBS_KP_PRE_HI:ofbs_pkg::OFBS_KP_PRE_LO];
        clkrec_integral_after_sync = bit_sync_config_q[ofbs_pkg::OFBS_KI_POST_BIT];
        clkrec_proportional_after_sync = bit_sync_config_q[ofbs_pkg::OFBS_KP_POST_BIT];
        rate_offset_saturation = bit_sync_config_q[ofbs_pkg::OFBS_RLIM_HI:ofbs_pkg::OFBS_RLIM_LO];
    end

    // address decode for both registers
    always_comb
    begin
        hit_freq = (cfg_addr_in == ofbs_pkg::OFBS_ADDR_FREQ_CFG);
        hit_bsync = (cfg_addr_in == ofbs_pkg::OFBS_ADDR_BSYNC_CFG);
    end

    // frequency register write, unused top bits held at zero
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            freq_offset_comp_config_q <= ofbs_pkg::OFBS_FREQ_CFG_RESET;
        end
        else if (cfg_wr_in && hit_freq)
        begin
            freq_offset_comp_config_q <= cfg_wdata_in & ofbs_pkg::OFBS_FREQ_CFG_MASK;
        end
    end

    // bit-sync register write, all bits writable
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            bit_sync_config_q <= ofbs_pkg::OFBS_BSYNC_CFG_RESET;
        end
        else if (cfg_wr_in && hit_bsync)
        begin
            bit_sync_config_q <= cfg_wdata_in;
        end
    end

    // read data register, unmapped addresses read zero
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cfg_rdata_q <= 8'h00;
        end
        else if (cfg_rd_in)
        begin
            if (hit_freq)
            begin
                cfg_rdata_q <= freq_offset_comp_config_q;
            end
            else if (hit_bsync)
            begin
                cfg_rdata_q <= bit_sync_config_q;
            end
            else
            begin
                cfg_rdata_q <= 8'h00;
            end
        end
    end

    // reception phase: sync moves forward, new reception resets
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            phase_q <= ofbs_pkg::OFBS_WAIT_SYNC;
        end
        else
        begin
            unique case (phase_q)
                ofbs_pkg::OFBS_WAIT_SYNC:
                begin
                    // sync word switches gains over
                    if (sync_found_in)
                    begin
                        phase_q <= ofbs_pkg::OFBS_SYNCED;
                    end
                end
                ofbs_pkg::OFBS_SYNCED:
                begin
                    // a new reception returns to pre-sync gains
                    if (rx_start_in && !sync_found_in)
                    begin
                        phase_q <= ofbs_pkg::OFBS_WAIT_SYNC;
                    end
                end
            endcase
        end
    end

    // phase as a plain level
    always_comb
    begin
        after_sync = (phase_q == ofbs_pkg::OFBS_SYNCED);
    end

    // carrier seen latch, cleared at reception start, set wins
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            carrier_seen_q <= 1'b0;
        end
        else if (carrier_sense_in)
        begin
            carrier_seen_q <= 1'b1;
        end
        else if (rx_start_in)
        begin
            carrier_seen_q <= 1'b0;
        end
    end

    // freeze both loops while gated and no carrier yet
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            loop_freeze_q <= 1'b1;
        end
        else
        begin
            loop_freeze_q <= loop_freeze_until_carrier && !carrier_sense_in
                && (!carrier_seen_q || rx_start_in);
        end
    end

    // frequency saturation decode; the host keeps zero for keying
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            freq_comp_enable_q <= 1'b1;
            freq_limit_shift_q <= ofbs_pkg::OFBS_FSHIFT_DIV4;
        end
        else
        begin
            freq_comp_enable_q <= (freq_offset_saturation != ofbs_pkg::OFBS_LIM_OFF);
            unique case (freq_offset_saturation)
                ofbs_pkg::OFBS_LIM_OFF: freq_limit_shift_q <= ofbs_pkg::OFBS_FSHIFT_NONE;
                ofbs_pkg::OFBS_LIM_1: freq_limit_shift_q <= ofbs_pkg::OFBS_FSHIFT_DIV8;
                ofbs_pkg::OFBS_LIM_2: freq_limit_shift_q <= ofbs_pkg::OFBS_FSHIFT_DIV4;
                ofbs_pkg::OFBS_LIM_3: freq_limit_shift_q <= ofbs_pkg::OFBS_FSHIFT_DIV2;
            endcase
        end
    end

    // data-rate saturation decode
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rate_comp_enable_q <= 1'b0;
            rate_limit_shift_q <= ofbs_pkg::OFBS_RSHIFT_NONE;
        end
        else
        begin
            rate_comp_enable_q <= (rate_offset_saturation != ofbs_pkg::OFBS_LIM_OFF);
            unique case (rate_offset_saturation)
                ofbs_pkg::OFBS_LIM_OFF: rate_limit_shift_q <= ofbs_pkg::OFBS_RSHIFT_NONE;
                ofbs_pkg::OFBS_LIM_1: rate_limit_shift_q <= ofbs_pkg::OFBS_RSHIFT_DIV32;
                ofbs_pkg::OFBS_LIM_2: rate_limit_shift_q <= ofbs_pkg::OFBS_RSHIFT_DIV16;
                ofbs_pkg::OFBS_LIM_3: rate_limit_shift_q <= ofbs_pkg::OFBS_RSHIFT_DIV8;
            endcase
        end
    end

    // gather selector inputs per loop
    always_comb
    begin
        pre_codes[ofbs_pkg::OFBS_LOOP_FREQ] = freq_gain_before_sync;
        pre_codes[ofbs_pkg::OFBS_LOOP_KI] = clkrec_integral_before_sync;
        pre_codes[ofbs_pkg::OFBS_LOOP_KP] = clkrec_proportional_before_sync;
        post_bits[ofbs_pkg::OFBS_LOOP_FREQ] = freq_gain_after_sync;
        post_bits[ofbs_pkg::OFBS_LOOP_KI] = clkrec_integral_after_sync;
        post_bits[ofbs_pkg::OFBS_LOOP_KP] = clkrec_proportional_after_sync;
    end

    // one gain selector per loop
    generate
        for (genvar i = 0; i < ofbs_pkg::OFBS_LOOPS; i++)
        begin : g_loop
            ofbs_gain_sel u_sel
            (
                .clk_in(clk_in),
                .resetn_in(resetn_in),
                .pre_code_in(pre_codes[i]),
                .post_bit_in(post_bits[i]),
                .post_gain_in(ofbs_pkg::OFBS_POST_GAIN[i]),
                .after_sync_in(after_sync),
                .gain_out(gains[i])
            );
        end
    endgenerate

    // output drive
    assign cfg_rdata_out = cfg_rdata_q;
    assign cfg_hit_out = hit_freq || hit_bsync;
    assign freq_gain_out = gains[ofbs_pkg::OFBS_LOOP_FREQ];
    assign clkrec_integral_gain_out = gains[ofbs_pkg::OFBS_LOOP_KI];
    assign clkrec_proportional_gain_out = gains[ofbs_pkg::OFBS_LOOP_KP];
    assign freq_comp_enable_out = freq_comp_enable_q;
    assign freq_limit_shift_out = freq_limit_shift_q;
    assign rate_comp_enable_out = rate_comp_enable_q;
    assign rate_limit_shift_out = rate_limit_shift_q;
    assign loop_freeze_out = loop_freeze_q;
    assign after_sync_out = after_sync;

endmodule : ofbs_loop_config

//--- testbench/ofbs_loop_config_assertions.sv
// port-level checker for the loop configuration block
// assumes one clock domain and the active-low asynchronous reset
module ofbs_loop_config_checker
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [5:0] cfg_addr_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_wdata_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_rdata_out,
    input wire logic cfg_hit_out,
    // demodulator events
    input wire logic rx_start_in,
    input wire logic sync_found_in,
    input wire logic carrier_sense_in,
    // loop controls
    input wire logic [3:0] freq_gain_out,
    input wire logic freq_comp_enable_out,
    input wire logic [2:0] freq_limit_shift_out,
    input wire logic [3:0] clkrec_integral_gain_out,
    input wire logic [3:0] clkrec_proportional_gain_out,
    input wire logic rate_comp_enable_out,
    input wire logic [2:0] rate_limit_shift_out,
    input wire logic loop_freeze_out,
    input wire logic after_sync_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // every check samples on the rising edge, idle in reset
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_hit_decode: assert property (cfg_hit_out == (cfg_addr_in == 6'h19 || cfg_addr_in == 6'h1A))
        else $error("address hit decode wrong");
    a_unmapped_zero: assert property (cfg_rd_in && !cfg_hit_out |=> cfg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!cfg_rd_in |=> $stable(cfg_rdata_out))
        else $error("read data moved without read");
    a_sync_enters: assert property (sync_found_in |=> after_sync_out)
        else $error("sync did not enter synced phase");
    a_start_leaves: assert property (rx_start_in && !sync_found_in |=> !after_sync_out)
        else $error("reception start did not leave synced phase");
    a_phase_holds: assert property (!sync_found_in && !rx_start_in |=> $stable(after_sync_out))
        else $error("phase moved without event");
    a_freq_enable: assert property (freq_comp_enable_out == (freq_limit_shift_out != 3'h0))
        else $error("freq enable and limit disagree");
    a_rate_enable: assert property (rate_comp_enable_out == (rate_limit_shift_out != 3'h0))
        else $error("rate enable and limit disagree");
    a_carrier_unfreeze: assert property (carrier_sense_in |=> !loop_freeze_out)
        else $error("loops still frozen after carrier");
    a_shift_range: assert property (freq_limit_shift_out <= 3'h3 && rate_limit_shift_out != 3'h1)
        else $error("limit shift out of range");
endmodule : ofbs_loop_config_checker

//--- testbench/ofbs_host_model.sv
// host side model driving the configuration register port
// assumes it changes signals on the falling edge only
module ofbs_host_model
(
    // clock
    input wire logic clk_in,
    // register port
    output logic [5:0] cfg_addr_out,
    output logic cfg_wr_out,
    output logic [7:0] cfg_wdata_out,
    output logic cfg_rd_out,
    input wire logic [7:0] cfg_rdata_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // host on-off keying selection, off at time zero, set by the bench
    logic keying_mode = 1'b0;

    // idle bus at time zero
    initial
    begin
        cfg_addr_out = 6'h00;
        cfg_wr_out = 1'b0;
        cfg_wdata_out = 8'hA5;
        cfg_rd_out = 1'b0;
    end

    // one write, taken at the rising edge in the middle; host keeps
    // the freq limit at zero whenever keying is selected
    task wr_reg(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] dd;
        dd = (keying_mode && a == 6'h19) ? (d & 8'hFC) : d;
        @(negedge clk_in);
        cfg_addr_out = a;
        cfg_wdata_out = dd;
        cfg_wr_out = 1'b1;
        @(negedge clk_in);
        cfg_wr_out = 1'b0;
        cfg_wdata_out = ~dd;
    endtask : wr_reg

    // one read, data sampled after the taking edge
    task rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_in);
        cfg_addr_out = a;
        cfg_rd_out = 1'b1;
        @(negedge clk_in);
        cfg_rd_out = 1'b0;
        cfg_addr_out = ~a;
        d = cfg_rdata_in;
    endtask : rd_reg
endmodule : ofbs_host_model

//--- testbench/tb.sv
// self-checking bench for the loop configuration block
// assumes a 25 MHz clock and a host model on the register port
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_in = 1'b0; // bench clock
    logic resetn_in = 1'b0; // chip reset
    logic rx_start_in = 1'b0, sync_found_in = 1'b0, carrier_sense_in = 1'b0; // events
    logic [5:0] cfg_addr_in;
    logic cfg_wr_in, cfg_rd_in, cfg_hit_out, freq_comp_enable_out, rate_comp_enable_out;
    logic loop_freeze_out, after_sync_out;
    logic [7:0] cfg_wdata_in, cfg_rdata_out, rd, f, b;
    logic [3:0] freq_gain_out, clkrec_integral_gain_out, clkrec_proportional_gain_out;
    logic [2:0] freq_limit_shift_out, rate_limit_shift_out;
    logic [31:0] seed = 32'h7BA2; // random state
    int fail_count = 0, total_checks = 0, cycles = 0;

    // clock generator
    initial
    begin
        forever #20 clk_in = ~clk_in;
    end

    ofbs_host_model host (.clk_in(clk_in), .cfg_addr_out(cfg_addr_in), .cfg_wr_out(cfg_wr_in),
        .cfg_wdata_out(cfg_wdata_in), .cfg_rd_out(cfg_rd_in), .cfg_rdata_in(cfg_rdata_out));

    ofbs_loop_config uut (.clk_in(clk_in), .resetn_in(resetn_in), .cfg_addr_in(cfg_addr_in),
        .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rd_in(cfg_rd_in),
        .cfg_rdata_out(cfg_rdata_out), .cfg_hit_out(cfg_hit_out), .rx_start_in(rx_start_in),
        .sync_found_in(sync_found_in), .carrier_sense_in(carrier_sense_in),
        .freq_gain_out(freq_gain_out), .freq_comp_enable_out(freq_comp_enable_out),
        .freq_limit_shift_out(freq_limit_shift_out), .clkrec_integral_gain_out(clkrec_integral_gain_out),
        .clkrec_proportional_gain_out(clkrec_proportional_gain_out),
        .rate_comp_enable_out(rate_comp_enable_out), .rate_limit_shift_out(rate_limit_shift_out),
        .loop_freeze_out(loop_freeze_out), .after_sync_out(after_sync_out));

    // next random word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // pre-sync gain in halves: code plus one times base
    function automatic logic [3:0] pre_g(input logic [1:0] c);
        return {1'b0, c, 1'b0} + 4'h2;
    endfunction : pre_g

    // pulse events for one cycle, then wait for outputs to settle
    task ev(input logic [2:0] v);
        @(negedge clk_in);
        {rx_start_in, sync_found_in, carrier_sense_in} = v;
        @(negedge clk_in);
        {rx_start_in, sync_found_in, carrier_sense_in} = 3'h0;
        repeat (2) @(negedge clk_in);
    endtask : ev

    // compare all loop controls except the freeze against register contents
    task chk_out(input logic s);
        logic [1:0] fl, rl;
        fl = f[1:0];
        rl = b[1:0];
        `CHK("freq_gain", (s && f[2]) ? 4'h1 : pre_g(f[4:3]), freq_gain_out)
        `CHK("ki_gain", (s && b[3]) ? 4'h1 : pre_g(b[7:6]), clkrec_integral_gain_out)
        `CHK("kp_gain", (s && b[2]) ? 4'h2 : pre_g(b[5:4]), clkrec_proportional_gain_out)
        `CHK("freq_en", fl != 2'h0, freq_comp_enable_out)
        `CHK("freq_shift", (fl == 2'h0) ? 3'h0 : 3'h4 - {1'b0, fl}, freq_limit_shift_out)
        `CHK("rate_en", rl != 2'h0, rate_comp_enable_out)
        `CHK("rate_shift", (rl == 2'h0) ? 3'h0 : 3'h6 - {1'b0, rl}, rate_limit_shift_out)
        `CHK("phase", s, after_sync_out)
    endtask : chk_out

    // verdict
    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // hang guard
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    // main sequence
    initial
    begin
        repeat (10) @(negedge clk_in);
        resetn_in = 1'b1;
        repeat (2) @(negedge clk_in);
        f = 8'h36;
        b = 8'h6C;
        host.rd_reg(6'h19, rd);
        `CHK("freq_reg_reset", 8'h36, rd)
        host.rd_reg(6'h1A, rd);
        `CHK("bsync_reg_reset", 8'h6C, rd)
        chk_out(1'b0);
        `CHK("freeze_reset", 1'b1, loop_freeze_out)
        host.rd_reg(6'h1B, rd);
        `CHK("unmapped_read", 8'h00, rd)
        $display("test reset done");
        for (int i = 0; i < 40; i++)
        begin
            seed = lfsr(seed);
            f = (i == 0) ? 8'hFF : (i == 1) ? 8'h07 : seed[7:0];
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[15:8];
            host.keying_mode = (i % 5 == 4);
            host.wr_reg(6'h19, f);
            host.wr_reg(6'h1A, b);
            f = f & (host.keying_mode ? 8'h3C : 8'h3F);
            host.rd_reg(6'h19, rd);
            `CHK("freq_reg", f, rd)
            host.rd_reg(6'h1A, rd);
            `CHK("bsync_reg", b, rd)
            ev(3'h4);
            chk_out(1'b0);
            `CHK("freeze", f[5], loop_freeze_out)
            ev(3'h1);
            `CHK("freeze_cs", 1'b0, loop_freeze_out)
            ev(3'h2);
            chk_out(1'b1);
            `CHK("freeze_held", 1'b0, loop_freeze_out)
            ev(3'h6);
            chk_out(1'b1);
            `CHK("freeze_rearm", f[5], loop_freeze_out)
            ev(3'h4);
            chk_out(1'b0);
        end
        $display("test random done");
        end_of_test();
    end
endmodule : tb

bind ofbs_loop_config ofbs_loop_config_checker chk (.clk_in(clk_in), .resetn_in(resetn_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rd_in(cfg_rd_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_hit_out(cfg_hit_out), .rx_start_in(rx_start_in),
    .sync_found_in(sync_found_in), .carrier_sense_in(carrier_sense_in), .freq_gain_out(freq_gain_out),
    .freq_comp_enable_out(freq_comp_enable_out), .freq_limit_shift_out(freq_limit_shift_out),
    .clkrec_integral_gain_out(clkrec_integral_gain_out),
    .clkrec_proportional_gain_out(clkrec_proportional_gain_out),
    .rate_comp_enable_out(rate_comp_enable_out), .rate_limit_shift_out(rate_limit_shift_out),
    .loop_freeze_out(loop_freeze_out), .after_sync_out(after_sync_out));
